// ===== emp_clock_strobe.sv
// Module: clock source selection, output clocks and shared strobe pins
// Operation
// - Strap choosing input pin, CPU/4 or CPU/6 clock is latched once, on the first clock after reset release
// - Dedicated input clock pin is default source
// - Strap 00 pin, 01 CPU/4, 10 CPU/6; 11 reserved
// - Second output clock is selected clock divided by 1, 2 or 4
// - First output clock runs at selected clock rate
// - Read pin: async read, SDRAM column strobe, or sync address/read
// - Strobe select 0 gives address strobe, 1 gives read enable
// - Output enable pin: async OE, SDRAM row strobe, sync OE
// - Write pin: async write, SDRAM write enable, sync write enable
// - SDRAM clock enable output; low places SDRAM in self-refresh
// - Without SDRAM, clock enable pin is a software output
// - Dedicated sync output enable tied to chip select space three
// - Async memory ready input shows whether access can complete
module emp_clock_strobe (
    input  wire logic            clk,
    input  wire logic            rstn,
    input  wire logic            extMemInputClockPin,
    input  wire logic [1:0]      clockSourceStrap,
    input  wire logic [1:0]      divRatio,
    input  wire emp_pkg::emp_mem_t memType,
    input  wire logic            strobeSelectField,
    input  wire logic            spaceThree,
    input  wire logic            readReq,
    input  wire logic            oeReq,
    input  wire logic            writeReq,
    input  wire logic            sdramPresent,
    input  wire logic            selfRefreshReq,
    input  wire logic            gpoValue,
    input  wire logic            asyncReadyInput,
    output logic                 clockSourceSelect,
    output logic [1:0]           clockSourceCode,
    output logic                 extMemFullRateClockOut,
    output logic                 extMemDividedClockOut,
    output logic                 readPinN,
    output logic                 oePinN,
    output logic                 writePinN,
    output logic                 sdramClockEnableOut,
    output logic                 fifoSpaceOutputEnableN,
    output logic                 waitActive
);
    // ********************************
    // Synchronisers
    // ********************************
    logic [1:0] pinSync_r;
    logic [1:0] rdySync_r;
    logic [1:0] strapMeta_r;
    logic [1:0] strapSync_r;
    logic       strapDone_r;
    logic [2:0] cpuCnt_r;
    logic       cpuClk_r;
    logic       pinPrev_r;
    logic       srcTick;
    logic       srcLevel;
    logic       cpuWrap;
    logic [1:0] divCnt_r;
    logic       waitHold_r;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pinSync_r <= 2'h0;
            rdySync_r <= 2'h3;
        end else begin
            pinSync_r <= {pinSync_r[0], extMemInputClockPin};
            rdySync_r <= {rdySync_r[0], asyncReadyInput};
        end
    end

    // ********************************
    // Strap capture
    // ********************************
    // Strap pins settle while reset is held, so this pair runs without reset
    always_ff @(posedge clk) begin
        strapMeta_r <= clockSourceStrap;
        strapSync_r <= strapMeta_r;
    end

    // Captured after release, since an async reset may only load constants
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            strapDone_r     <= 1'h0;
            clockSourceCode <= emp_pkg::SRC_RESET;
        end else if (!strapDone_r) begin
            strapDone_r <= 1'h1;
            if (strapSync_r == emp_pkg::SRC_RESERVED)
                clockSourceCode <= emp_pkg::SRC_RESET;
            else
                clockSourceCode <= strapSync_r;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            clockSourceSelect <= 1'h0;
        else
            clockSourceSelect <= strapDone_r;
    end

    // ********************************
    // Source clock generation
    // ********************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cpuCnt_r <= 3'h0;
            cpuClk_r <= 1'h0;
        end else if (cpuWrap) begin
            cpuCnt_r <= 3'h0;
            cpuClk_r <= ~cpuClk_r;
        end else begin
            cpuCnt_r <= cpuCnt_r + 3'h1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            pinPrev_r <= 1'h0;
        else
            pinPrev_r <= srcLevel;
    end

    // Counter runs on in pin mode too; it only wraps there, harmlessly
    always_comb begin
        cpuWrap = 1'h0;
        if (clockSourceCode == emp_pkg::SRC_CPU_DIV4)
            cpuWrap = cpuCnt_r == emp_pkg::CPU_DIV4_HALF - 3'h1;
        else if (clockSourceCode == emp_pkg::SRC_CPU_DIV6)
            cpuWrap = cpuCnt_r == emp_pkg::CPU_DIV6_HALF - 3'h1;
    end

    always_comb begin
        srcLevel = (clockSourceCode == emp_pkg::SRC_INPUT_PIN) ? pinSync_r[1] : cpuClk_r;
        srcTick  = srcLevel != pinPrev_r;
    end

    // ********************************
    // Output clocks
    // ********************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            extMemFullRateClockOut <= 1'h0;
            extMemDividedClockOut  <= 1'h0;
            divCnt_r               <= 2'h0;
        end else if (srcTick) begin
            extMemFullRateClockOut <= ~extMemFullRateClockOut;
            divCnt_r               <= divCnt_r + 2'h1;
            case (divRatio)
                emp_pkg::DIV_BY2: begin
                    if (divCnt_r[0])
                        extMemDividedClockOut <= ~extMemDividedClockOut;
                end
                emp_pkg::DIV_BY4: begin
                    if (&divCnt_r)
                        extMemDividedClockOut <= ~extMemDividedClockOut;
                end
                default: begin
                    extMemDividedClockOut <= ~extMemDividedClockOut;
                end
            endcase
        end
    end

    // ********************************
    // Ready wait handling
    // ********************************
    // Wait only applies to async strobes; waitHold_r holds the strobe after the request drops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            waitHold_r <= 1'h0;
            waitActive <= 1'h0;
        end else begin
            waitHold_r <= memType == emp_pkg::MEM_ASYNC && (readReq || writeReq || waitHold_r)
                          && !rdySync_r[1];
            waitActive <= memType == emp_pkg::MEM_ASYNC && (readReq || writeReq || waitHold_r)
                          && !rdySync_r[1];
        end
    end

    // ********************************
    // Shared strobe pins
    // ********************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            readPinN  <= 1'h1;
            oePinN    <= 1'h1;
            writePinN <= 1'h1;
        end else begin
            case (memType)
                emp_pkg::MEM_SYNC:
                    readPinN <= !(strobeSelectField ? readReq : (readReq || writeReq));
                emp_pkg::MEM_ASYNC:
                    readPinN <= !(readReq || (waitHold_r && !readPinN));
                default:
                    readPinN <= !readReq;
            endcase
            oePinN    <= !oeReq;
            writePinN <= !(writeReq || (memType == emp_pkg::MEM_ASYNC && waitHold_r
                          && !writePinN));
        end
    end

    // ********************************
    // Clock enable and FIFO enable
    // ********************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sdramClockEnableOut    <= emp_pkg::CKE_RESET;
            fifoSpaceOutputEnableN <= 1'h1;
        end else begin
            sdramClockEnableOut    <= sdramPresent ? !selfRefreshReq : gpoValue;
            fifoSpaceOutputEnableN <= !(spaceThree && oeReq
                                        && memType == emp_pkg::MEM_SYNC);
        end
    end

    // ********************************
    // Checks
    // ********************************
    selfRefresh_a: assert property (@(posedge clk) disable iff (!rstn)
        sdramPresent && selfRefreshReq |=> !sdramClockEnableOut)
        else $error("clock enable not low in self-refresh");
    gpoFollow_a: assert property (@(posedge clk) disable iff (!rstn)
        !sdramPresent |=> sdramClockEnableOut == $past(gpoValue))
        else $error("clock enable not following software value");
    fifoOe_a: assert property (@(posedge clk) disable iff (!rstn)
        !spaceThree |=> fifoSpaceOutputEnableN)
        else $error("fifo enable outside space three");
    oePin_a: assert property (@(posedge clk) disable iff (!rstn)
        oeReq |=> !oePinN)
        else $error("output enable pin not asserted");
    syncAddr_a: assert property (@(posedge clk) disable iff (!rstn)
        memType == emp_pkg::MEM_SYNC && !strobeSelectField && writeReq |=> !readPinN)
        else $error("address strobe missing");
    writePin_a: assert property (@(posedge clk) disable iff (!rstn)
        writeReq |=> !writePinN)
        else $error("write pin not asserted");
    readPin_a: assert property (@(posedge clk) disable iff (!rstn)
        readReq && memType != emp_pkg::MEM_SYNC |=> !readPinN)
        else $error("read pin not asserted");
    strapLegal_a: assert property (@(posedge clk) disable iff (!rstn)
        clockSourceCode != emp_pkg::SRC_RESERVED)
        else $error("reserved clock source selected");
    fullRate_a: assert property (@(posedge clk) disable iff (!rstn)
        srcTick |=> extMemFullRateClockOut != $past(extMemFullRateClockOut))
        else $error("full rate clock missed a tick");
    holdStrobe_a: assert property (@(posedge clk) disable iff (!rstn)
        waitHold_r && !readPinN && memType == emp_pkg::MEM_ASYNC |=> !readPinN)
        else $error("read strobe dropped during wait");
    readCov: cover property (@(posedge clk) disable iff (!rstn) !readPinN);
    waitCov: cover property (@(posedge clk) disable iff (!rstn) waitActive);
    holdCov: cover property (@(posedge clk) disable iff (!rstn) waitHold_r && !readPinN);
    refreshCov: cover property (@(posedge clk) disable iff (!rstn) !sdramClockEnableOut);
endmodule

// ===== emp_pkg.sv
// Package: constants and types for the external memory port clock and strobe pins
package emp_pkg;
    // ********************************
    // Clock source strap codes
    // ********************************
    localparam logic [1:0] SRC_INPUT_PIN = 2'h0;
    localparam logic [1:0] SRC_CPU_DIV4  = 2'h1;
    localparam logic [1:0] SRC_CPU_DIV6  = 2'h2;
    localparam logic [1:0] SRC_RESERVED  = 2'h3;
    // ********************************
    // Divided clock ratio codes
    // ********************************
    localparam logic [1:0] DIV_BY1 = 2'h0;
    localparam logic [1:0] DIV_BY2 = 2'h1;
    localparam logic [1:0] DIV_BY4 = 2'h2;
    // ********************************
    // CPU clock division counts
    // ********************************
    localparam logic [2:0] CPU_DIV4_HALF = 3'h2;
    localparam logic [2:0] CPU_DIV6_HALF = 3'h3;
    // ********************************
    // Memory type codes
    // ********************************
    typedef enum logic [1:0] {MEM_ASYNC, MEM_SDRAM, MEM_SYNC} emp_mem_t;
    // ********************************
    // Reset values
    // ********************************
    localparam logic [1:0] SRC_RESET = 2'h0;
    localparam logic       CKE_RESET = 1'h1;
endpackage

// ===== emp_mem_model.sv
// Partner model: asynchronous memory answering on the ready pin
module emp_mem_model (
    input  wire logic clk,
    input  wire logic readPinN,
    input  wire logic writePinN,
    input  wire logic slow,
    output logic      asyncReadyInput
);
    timeunit 1ns;
    timeprecision 1ns;
    int waitCnt = 0;
    // Counts strobe cycles; saturates so ready stays high until slow drops
    always @(posedge clk) begin
        if (!slow) waitCnt <= 0;
        else if ((!readPinN || !writePinN) && waitCnt < 6) waitCnt <= waitCnt + 1;
    end
    // Pin has a pull-up: high whenever the memory is not stalling
    assign asyncReadyInput = !slow || waitCnt == 6;
endmodule

// ===== emp_clock_strobe_tb.sv
// Testbench: self-checking bench for the clock and strobe pin block
module emp_clock_strobe_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'h0, rstn = 1'h0, pin = 1'h0, sSel = 1'h0, sp3 = 1'h0, rdq = 1'h0;
    logic oeq = 1'h0, wrq = 1'h0, sdP = 1'h1, srq = 1'h0, gpo = 1'h0, slow = 1'h0;
    logic rdy, cSel, full, divd, rdN, oeN, wrN, cke, fifoN, waitAct;
    logic [1:0] strap = 2'h0, divR = 2'h0, code;
    emp_pkg::emp_mem_t memType = emp_pkg::MEM_ASYNC;
    int errorCnt = 0, checkCount = 0;
    emp_clock_strobe i_emp_clock_strobe (.clk(clk), .rstn(rstn), .extMemInputClockPin(pin),
        .clockSourceStrap(strap), .divRatio(divR), .memType(memType),
        .strobeSelectField(sSel), .spaceThree(sp3), .readReq(rdq), .oeReq(oeq),
        .writeReq(wrq), .sdramPresent(sdP), .selfRefreshReq(srq), .gpoValue(gpo),
        .asyncReadyInput(rdy), .clockSourceSelect(cSel), .clockSourceCode(code),
        .extMemFullRateClockOut(full), .extMemDividedClockOut(divd), .readPinN(rdN),
        .oePinN(oeN), .writePinN(wrN), .sdramClockEnableOut(cke),
        .fifoSpaceOutputEnableN(fifoN), .waitActive(waitAct));
    emp_mem_model i_emp_mem_model (.clk(clk), .readPinN(rdN), .writePinN(wrN),
        .slow(slow), .asyncReadyInput(rdy));
    initial forever #50 clk = ~clk;
    always begin
        repeat (2) @(negedge clk);
        pin = ~pin;
    end
    // ********************************
    // Compare and helper tasks
    // ********************************
    task automatic chkb(input logic g, input logic e);
        checkCount++;
        if (g !== e) begin
            errorCnt++;
            $display("wrong value %0t pin %b expected %b", $time, g, e);
        end
    endtask
    task automatic chkc(input logic [1:0] g, input logic [1:0] e);
        checkCount++;
        if (g !== e) begin
            errorCnt++;
            $display("wrong value %0t code %h expected %h", $time, g, e);
        end
    endtask
    // Phase of the source clock is unknown, so one toggle of slack
    task automatic chkn(input int g, input int e);
        checkCount++;
        if (g < e - 1 || g > e + 1) begin
            errorCnt++;
            $display("wrong value %0t toggles %0d expected %0d", $time, g, e);
        end
    endtask
    task automatic conclude;
        if (errorCnt == 0 && checkCount > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic rst(input logic [1:0] s, input int n);
        rstn = 1'h0;
        strap = s;
        repeat (n) @(negedge clk);
        rstn = 1'h1;
        repeat (3) @(negedge clk);
    endtask
    // ********************************
    // Scenarios
    // ********************************
    task automatic t_straps;
        for (int s = 0; s < 4; s++) begin
            rst(s[1:0], 2);
            chkc(code, (s == 3) ? 2'h0 : s[1:0]);
            chkb(cSel, 1'h1);
        end
    endtask
    task automatic t_clocks;
        int nf, nd, per;
        for (int s = 0; s < 3; s++) for (int d = 0; d < 3; d++) begin
            rst(s[1:0], 2);
            divR = d[1:0];
            // Bench pin toggles every two clocks, as fast as CPU/4
            per = (s == 2) ? 3 : 2;
            nf = 0;
            nd = 0;
            repeat (4) @(negedge clk);
            for (int c = 0; c < 48; c++) begin
                logic f0, d0;
                f0 = full;
                d0 = divd;
                @(negedge clk);
                nf += (full !== f0);
                nd += (divd !== d0);
            end
            chkn(nf, 48 / per);
            chkn(nd, (48 / per) >> d);
        end
    endtask
    task automatic t_strobes;
        for (int i = 0; i < 4; i++) begin
            memType = (i > 2) ? emp_pkg::MEM_SYNC : emp_pkg::emp_mem_t'(i[1:0]);
            sSel = (i == 3);
            rdq = 1'h1;
            @(negedge clk);
            chkb(rdN, 1'h0);
            rdq = 1'h0;
            oeq = 1'h1;
            @(negedge clk);
            chkb(oeN, 1'h0);
            oeq = 1'h0;
            wrq = 1'h1;
            @(negedge clk);
            chkb(wrN, 1'h0);
            chkb(rdN, i != 2);
            wrq = 1'h0;
            repeat (4) @(negedge clk);
            chkb(rdN & oeN & wrN, 1'h1);
        end
    endtask
    task automatic cke_set(input logic p, input logic s, input logic g, input logic e);
        sdP = p;
        srq = s;
        gpo = g;
        repeat (2) @(negedge clk);
        chkb(cke, e);
    endtask
    // Ready is seen two clocks late, so the strobe outlasts it briefly
    task automatic t_wait(input logic rd);
        int n;
        slow = 1'h0;
        repeat (3) @(negedge clk);
        slow = 1'h1;
        repeat (3) @(negedge clk);
        rdq = rd;
        wrq = !rd;
        @(negedge clk);
        rdq = 1'h0;
        wrq = 1'h0;
        repeat (3) @(negedge clk);
        chkb(rd ? rdN : wrN, 1'h0);
        chkb(rd ? wrN : rdN, 1'h1);
        chkb(waitAct, 1'h1);
        for (n = 0; n < 20 && (rdN & wrN) !== 1'h1; n++) @(negedge clk);
        chkb(rdN & wrN, 1'h1);
        chkb(waitAct, 1'h0);
        slow = 1'h0;
    endtask
    task automatic t_fifo_wait;
        memType = emp_pkg::MEM_SYNC;
        sp3 = 1'h1;
        oeq = 1'h1;
        @(negedge clk);
        chkb(fifoN, 1'h0);
        sp3 = 1'h0;
        repeat (2) @(negedge clk);
        chkb(fifoN, 1'h1);
        oeq = 1'h0;
        memType = emp_pkg::MEM_ASYNC;
        t_wait(1'h0);
        t_wait(1'h1);
    endtask
    initial begin
        #200000;
        errorCnt++;
        conclude();
    end
    initial begin
        rst(2'h0, 10);
        t_straps();
        t_clocks();
        t_strobes();
        cke_set(1'h1, 1'h0, 1'h0, 1'h1);
        cke_set(1'h1, 1'h1, 1'h1, 1'h0);
        cke_set(1'h0, 1'h0, 1'h0, 1'h0);
        cke_set(1'h0, 1'h0, 1'h1, 1'h1);
        t_fifo_wait();
        conclude();
    end
endmodule
